// ---- design/edge_if.sv ----
/*
 * Interface between the register logic and the per-pin edge detectors.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface edge_if;
    import pin_change_pkg::*;
    logic [PINS-1:0] rise_en;
    logic [PINS-1:0] fall_en;
    logic [PINS-1:0] hit;
    logic [PINS-1:0] level;
    modport ctrl (output rise_en, output fall_en, input hit, input level);
    modport det (input rise_en, input fall_en, output hit, output level);
endinterface
`default_nettype wire

// ---- design/pin_change_interrupt.sv ----
/*
 * Pin-change interrupt block for an eight-bit port: per-pin rising and
 * falling edge detection, sticky change flags, summary flag, interrupt
 * and wake request, and a small register port.
 * Assumes a register master on mclk with one-cycle strobes and a sleep
 * indication from the core on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt
    import pin_change_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    // port pins
    input wire logic [PINS-1:0] port_pins,
    // core
    input wire logic sleep_mode,
    output logic change_summary_flag,
    output logic wake_req,
    output logic irq
);

    // ----------------------------------------------------------------
    // reset and detectors
    // ----------------------------------------------------------------
    logic rst_n_sync;
    edge_if edges ();

    reset_sync u_reset_sync (
        .mclk(mclk),
        .rstn(rstn),
        .rst_n_sync(rst_n_sync)
    );

    pin_edge_detect u_detect (
        .mclk(mclk),
        .rst_n(rst_n_sync),
        .pins(port_pins),
        .det(edges.det)
    );

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [PINS-1:0] rising_enable_reg;
    logic [PINS-1:0] rising_enable_next;
    logic [PINS-1:0] falling_enable_reg;
    logic [PINS-1:0] falling_enable_next;
    logic [PINS-1:0] change_flag_reg;
    logic [PINS-1:0] change_flag_next;
    logic master_enable_reg;
    logic master_enable_next;
    logic [DATA_W-1:0] irq_stat_reg;
    logic [DATA_W-1:0] irq_stat_next;
    logic [DATA_W-1:0] irq_mask_reg;
    logic [DATA_W-1:0] irq_mask_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic summary_reg;
    logic summary_next;
    logic wake_reg;
    logic wake_next;
    logic irq_reg;
    logic irq_next;

    logic wr_rise;
    logic wr_fall;
    logic wr_flag;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic [DATA_W-1:0] events;
    logic [DATA_W-1:0] ctrl_view;

    assign wr_rise = wr_stb && (addr == ADDR_RISE);
    assign wr_fall = wr_stb && (addr == ADDR_FALL);
    assign wr_flag = wr_stb && (addr == ADDR_FLAG);
    assign wr_ctrl = wr_stb && (addr == ADDR_CTRL);
    assign wr_stat = wr_stb && (addr == ADDR_IRQ_STAT);
    assign wr_mask = wr_stb && (addr == ADDR_IRQ_MASK);

    assign edges.rise_en = rising_enable_reg;
    assign edges.fall_en = falling_enable_reg;

    // ----------------------------------------------------------------
    // next-state computation
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_view = READ_ZERO;
        ctrl_view[CTRL_MASTER_BIT] = master_enable_reg;
        ctrl_view[CTRL_SUMMARY_BIT] = summary_reg;

        rising_enable_next = wr_rise ? wdata : rising_enable_reg;
        falling_enable_next = wr_fall ? wdata : falling_enable_reg;
        master_enable_next = wr_ctrl ? wdata[CTRL_MASTER_BIT] : master_enable_reg;
        irq_mask_next = wr_mask ? wdata : irq_mask_reg;

        // a hit in the same cycle as a write always wins
        if (wr_flag) begin
            change_flag_next = wdata | edges.hit;
        end else begin
            change_flag_next = change_flag_reg | edges.hit;
        end

        summary_next = |change_flag_next;
        // flags are already in place when the wake request rises
        wake_next = sleep_mode && master_enable_reg && summary_reg;

        events = READ_ZERO;
        events[EVT_EDGE_BIT] = |edges.hit;
        events[EVT_WAKE_BIT] = wake_next && !wake_reg;
        irq_stat_next = (irq_stat_reg & ~(wr_stat ? wdata : READ_ZERO)) | events;

        // no interrupt leaves the block from the cycle after the master enable is clear
        irq_next = master_enable_reg && |(irq_stat_reg & irq_mask_reg);

        rdata_next = READ_ZERO;
        if (rd_stb) begin
            case (addr)
                ADDR_RISE: begin
                    rdata_next = rising_enable_reg;
                end
                ADDR_FALL: begin
                    rdata_next = falling_enable_reg;
                end
                ADDR_FLAG: begin
                    rdata_next = change_flag_reg;
                end
                ADDR_CTRL: begin
                    rdata_next = ctrl_view;
                end
                ADDR_IRQ_STAT: begin
                    rdata_next = irq_stat_reg;
                end
                ADDR_IRQ_MASK: begin
                    rdata_next = irq_mask_reg;
                end
                ADDR_LEVEL: begin
                    rdata_next = edges.level;
                end
                default: begin
                    rdata_next = READ_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rising_enable_reg <= RESET_ENABLE;
            falling_enable_reg <= RESET_ENABLE;
            change_flag_reg <= RESET_FLAG;
            master_enable_reg <= 1'b0;
            irq_stat_reg <= RESET_STAT;
            irq_mask_reg <= RESET_MASK;
            rdata_reg <= READ_ZERO;
            summary_reg <= 1'b0;
            wake_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            rising_enable_reg <= rising_enable_next;
            falling_enable_reg <= falling_enable_next;
            change_flag_reg <= change_flag_next;
            master_enable_reg <= master_enable_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
            summary_reg <= summary_next;
            wake_reg <= wake_next;
            irq_reg <= irq_next;
        end
    end

    assign rdata = rdata_reg;
    assign change_summary_flag = summary_reg;
    assign wake_req = wake_reg;
    assign irq = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n_sync);

    sequence s_flag_write;
        wr_stb && (addr == ADDR_FLAG);
    endsequence

    sequence s_ctrl_read;
        rd_stb && (addr == ADDR_CTRL);
    endsequence

    sequence s_wake_cause;
        sleep_mode && master_enable_reg && (|change_flag_reg);
    endsequence

    property p_rise_only_armed;
        (edges.hit & edges.level & ~rising_enable_reg) == '0;
    endproperty
    a_rise_only_armed: assert property (p_rise_only_armed)
        else $error("rising hit on a pin without rising enable");

    property p_fall_only_armed;
        (edges.hit & ~edges.level & ~falling_enable_reg) == '0;
    endproperty
    a_fall_only_armed: assert property (p_fall_only_armed)
        else $error("falling hit on a pin without falling enable");

    property p_both_edges;
        ((rising_enable_reg & falling_enable_reg) & (edges.level ^ $past(edges.level)))
            == ((rising_enable_reg & falling_enable_reg) & edges.hit);
    endproperty
    a_both_edges: assert property (p_both_edges)
        else $error("pin with both enables missed a level change");

    property p_edge_sets_flag;
        (|edges.hit) |=> ((change_flag_reg & $past(edges.hit)) == $past(edges.hit));
    endproperty
    a_edge_sets_flag: assert property (p_edge_sets_flag)
        else $error("detected edge did not set its flag");

    property p_flag_sticky;
        !wr_flag |=> ((change_flag_reg & $past(change_flag_reg)) == $past(change_flag_reg));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a write");

    property p_flag_write;
        s_flag_write |=> (change_flag_reg == ($past(wdata) | $past(edges.hit)));
    endproperty
    a_flag_write: assert property (p_flag_write)
        else $error("flag write gave the wrong value");

    property p_irq_needs_master;
        !master_enable_reg |=> !irq;
    endproperty
    a_irq_needs_master: assert property (p_irq_needs_master)
        else $error("interrupt raised with master enable clear");

    property p_summary_read;
        s_ctrl_read ##1 1'b1 |-> rdata[CTRL_SUMMARY_BIT] == (|$past(change_flag_reg));
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("summary flag is not the OR of the flags");

    property p_wake;
        s_wake_cause |=> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake request on a pin change in sleep");

    property p_wake_after_flag;
        wake_req |-> $past(|change_flag_reg);
    endproperty
    a_wake_after_flag: assert property (p_wake_after_flag)
        else $error("wake request before flags were updated");

    property p_reset_values;
        $rose(rst_n_sync) |-> (change_flag_reg == '0) && (rising_enable_reg == '0)
            && (falling_enable_reg == '0);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("registers not zero after reset");

    property p_detect_without_master;
        !master_enable_reg && (|edges.hit) |=> (|change_flag_reg) && irq_stat_reg[EVT_EDGE_BIT];
    endproperty
    a_detect_without_master: assert property (p_detect_without_master)
        else $error("detection stopped while master enable clear");

    property p_summary_level;
        change_summary_flag == (|change_flag_reg);
    endproperty
    a_summary_level: assert property (p_summary_level)
        else $error("summary output differs from the OR of the flags");

    property p_no_hit_unarmed;
        (edges.hit & ~(rising_enable_reg | falling_enable_reg)) == '0;
    endproperty
    a_no_hit_unarmed: assert property (p_no_hit_unarmed)
        else $error("hit on a pin with both enables clear");

    property p_rise_write;
        wr_rise |=> (rising_enable_reg == $past(wdata));
    endproperty
    a_rise_write: assert property (p_rise_write)
        else $error("rising enable write did not land");

    property p_fall_write;
        wr_fall |=> (falling_enable_reg == $past(wdata));
    endproperty
    a_fall_write: assert property (p_fall_write)
        else $error("falling enable write did not land");

    property p_irq_level;
        irq == ($past(master_enable_reg) && (|$past(irq_stat_reg & irq_mask_reg)));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level does not follow status, mask and master enable");

    property p_stat_edge_event;
        (|edges.hit) |=> irq_stat_reg[EVT_EDGE_BIT];
    endproperty
    a_stat_edge_event: assert property (p_stat_edge_event)
        else $error("detected edge did not set the edge event status bit");

    property p_wake_needs_master;
        wake_req |-> $past(master_enable_reg) && $past(sleep_mode);
    endproperty
    a_wake_needs_master: assert property (p_wake_needs_master)
        else $error("wake request without master enable or sleep");

    property p_wake_ends;
        !sleep_mode |=> !wake_req;
    endproperty
    a_wake_ends: assert property (p_wake_ends)
        else $error("wake request held after sleep ended");

    property p_rdata_idle;
        !$past(rd_stb) |-> (rdata == READ_ZERO);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside the read answer cycle");

endmodule
`default_nettype wire

// ---- design/pin_change_pkg.sv ----
/*
 * Constants for the pin-change interrupt block: register offsets,
 * field positions and reset values.
 * Assumes an 8-bit register port and one 125 MHz system clock.
 */
package pin_change_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int PINS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RISE = 8'h00;
    localparam logic [7:0] ADDR_FALL = 8'h04;
    localparam logic [7:0] ADDR_FLAG = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_LEVEL = 8'h18;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;
    localparam int EVT_EDGE_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_ENABLE = 8'h00;
    localparam logic [7:0] RESET_FLAG = 8'h00;
    localparam logic [7:0] RESET_MASK = 8'h00;
    localparam logic [7:0] RESET_STAT = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// ---- design/pin_edge_detect.sv ----
/*
 * Per-pin synchroniser and armed edge detector.
 * Assumes pins are asynchronous to mclk and rst_n is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
    import pin_change_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // port pins
    input wire logic [PINS-1:0] pins,
    // towards the register logic
    edge_if.det det
);
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            logic meta_reg;
            logic sync_reg;
            logic prev_reg;
            logic prev_next;
            always_comb begin
                prev_next = sync_reg;
            end
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    prev_reg <= 1'b0;
                end else begin
                    meta_reg <= pins[i];
                    sync_reg <= meta_reg;
                    prev_reg <= prev_next;
                end
            end
            // compare the synchronised sample with the previous one
            assign det.hit[i] = (det.rise_en[i] & sync_reg & ~prev_reg) |
                                (det.fall_en[i] & ~sync_reg & prev_reg);
            assign det.level[i] = sync_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- design/reset_sync.sv ----
/*
 * Reset release synchroniser: asynchronous assertion, release after
 * two mclk edges.
 * Assumes rstn is an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
    input wire logic mclk,
    input wire logic rstn,
    output logic rst_n_sync
);
    logic [1:0] stage_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage_reg <= 2'h0;
        end else begin
            stage_reg <= {stage_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = stage_reg[1];
endmodule
`default_nettype wire

// ---- sim/pin_source.sv ----
/*
 * Model of the external drivers on the port pins.
 * Assumes levels are pushed just after a rising mclk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_source
    import pin_change_pkg::*;
(
    // clock
    input wire logic mclk,
    // port pins
    output var logic [PINS-1:0] pins
);
    initial begin
        pins = 8'h00;
    end

    // levels are held for many cycles, so no change is shorter than a period
    task automatic drive(input logic [PINS-1:0] v);
        @(posedge mclk);
        pins <= v;
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 * Self-checking testbench for the pin-change interrupt block.
 * Assumes the package, interface, design files and pin_source are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pin_change_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic sleep_mode = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [PINS-1:0] port_pins;
    logic summ;
    logic wake;
    logic irq;
    logic [7:0] rv;
    logic hit;
    int miscompares = 0;
    int checks = 0;

    always #4 mclk = ~mclk;

    pin_source src (.mclk(mclk), .pins(port_pins));

    pin_change_interrupt DUT (
        .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .port_pins(port_pins), .sleep_mode(sleep_mode),
        .change_summary_flag(summ), .wake_req(wake), .irq(irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        rv = rdata;
    endtask

    task automatic clear(input logic [7:0] seen);
        rd(ADDR_FLAG);
        wr(ADDR_FLAG, rv & ~seen);
    endtask

    // a pin change reaches irq within four edges and wake within four
    task automatic pins_to(input logic [7:0] v);
        src.drive(v);
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] al [8];
        al = '{ADDR_RISE, ADDR_FALL, ADDR_FLAG, ADDR_CTRL, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_LEVEL, 8'h20};
        foreach (al[i]) begin
            rd(al[i]);
            chk(rv, 8'h00);
        end
        chk({5'h00, irq, wake, summ}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_edges;
        wr(ADDR_RISE, 8'h05);
        wr(ADDR_FALL, 8'h06);
        pins_to(8'h07);
        rd(ADDR_FLAG);
        chk(rv, 8'h05);
        rd(ADDR_LEVEL);
        chk(rv, 8'h07);
        chk({7'h00, summ}, 8'h01);
        rd(ADDR_CTRL);
        chk(rv, 8'h02);
        clear(8'h05);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        chk({7'h00, summ}, 8'h00);
        pins_to(8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h06);
        repeat (20) @(posedge mclk);
        rd(ADDR_FLAG);
        chk(rv, 8'h06);
        clear(8'h06);
        wr(ADDR_FALL, 8'h00);
        wr(ADDR_RISE, 8'hff);
        pins_to(8'hff);
        rd(ADDR_FLAG);
        chk(rv, 8'hff);
        clear(8'hff);
        pins_to(8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        $display("test edges done");
    endtask

    task automatic t_irq;
        wr(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_RISE, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h01);
        pins_to(8'h01);
        chk({7'h00, irq}, 8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h01);
        rd(ADDR_IRQ_STAT);
        chk(rv & 8'h01, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h00, irq}, 8'h00);
        pins_to(8'h00);
        clear(8'h01);
        wr(ADDR_CTRL, 8'h00);
        $display("test irq done");
    endtask

    task automatic t_race;
        wr(ADDR_RISE, 8'h03);
        pins_to(8'h01);
        // second edge lands in the same cycle as the clearing write
        src.drive(8'h03);
        @(posedge mclk);
        wr(ADDR_FLAG, 8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h02);
        clear(8'h02);
        pins_to(8'h00);
        rd(ADDR_FLAG);
        chk(rv, 8'h00);
        $display("test race done");
    endtask

    task automatic t_sleep;
        hit = 1'b0;
        wr(ADDR_RISE, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        sleep_mode <= 1'b1;
        src.drive(8'h01);
        for (int i = 0; i < 20 && !hit; i++) begin
            @(posedge mclk);
            #1;
            hit = (wake === 1'b1);
        end
        chk({7'h00, hit}, 8'h01);
        chk({7'h00, summ}, 8'h01);
        if (!hit) begin
            finish_test;
        end
        rd(ADDR_IRQ_STAT);
        chk(rv & 8'h02, 8'h02);
        @(posedge mclk);
        sleep_mode <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h00, wake}, 8'h00);
        $display("test sleep done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        t_reset;
        t_edges;
        t_irq;
        t_race;
        t_sleep;
        finish_test;
    end
endmodule
`default_nettype wire
